// file: logic/hdsp_pkg.sv
// Constants and types shared by the haptic setup and playback block
//
// Summary of operation
// [RULE1] Ignore bus traffic for 250 us after power-up
// [RULE2] Host may raise enable during that wait
// [RULE3] Writing zero to mode register leaves standby
// [RULE4] Host skips calibration if already programmed
// [RULE5] Waveform RAM reached only through window registers
// [RULE6] Reset default is closed-loop bidirectional drive
// [RULE7] Standby bit or low enable gives low power
// [RULE8] Mode field and standby stored in one write
// [RULE9] Mode field decodes five playback sources
// [RULE10] Effect index slots from 0x04 to 0x0B
// [RULE11] Go bit starts stored effects internally
// [RULE12] Trigger pin starts effects in external modes
// [RULE13] Effects restart by repeated go or trigger
// [RULE14] Real-time mode drives latest written amplitude
// [RULE15] Control bit picks PWM or analog input
// [RULE16] Host sets wanted mode before playback
// [RULE17] Host returns device to low power afterwards
// [RULE18] Registers keep contents while in standby
package hdsp_pkg;
   // Register offsets
   localparam logic [7:0] REG_MODE   = 8'h01;
   localparam logic [7:0] REG_RTP    = 8'h02;
   localparam logic [7:0] REG_SEQ0   = 8'h04;
   localparam logic [7:0] REG_SEQ7   = 8'h0B;
   localparam logic [7:0] REG_GO     = 8'h0C;
   localparam logic [7:0] REG_LOOP1  = 8'h1B;
   localparam logic [7:0] REG_LOOP2  = 8'h1C;
   localparam logic [7:0] REG_LOOP3  = 8'h1D;
   localparam logic [7:0] REG_RAMHI  = 8'hFD;
   localparam logic [7:0] REG_RAMLO  = 8'hFE;
   localparam logic [7:0] REG_RAMDAT = 8'hFF;
   // Field positions
   localparam int STBY_BIT      = 6;  // mode_select
   localparam int GO_BIT        = 0;  // playback_launch
   localparam int UNIDIR_BIT    = 7;  // loop_config_second
   localparam int OPEN_LOOP_BIT = 5;  // loop_config_third
   localparam int ANALOG_BIT    = 1;  // loop_config_third
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h40;
   localparam logic [7:0] ZERO_RST = 8'h00;
   // Sizes
   localparam int SEQ_N  = 8;
   localparam int RAM_AW = 9;
   localparam int RAM_N  = 512;
   // Bus address of the device, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2D;
   // Timing
   localparam int CLK_KHZ    = 25000;
   localparam int PWRUP_US   = 250;
   localparam int PWRUP_CYC  = (PWRUP_US * CLK_KHZ + 999) / 1000;
   localparam int EFFECT_US  = 40;
   localparam int EFFECT_CYC = EFFECT_US * CLK_KHZ / 1000;
   // Playback sources of the mode field
   localparam logic [2:0] MD_INT   = 3'h0;
   localparam logic [2:0] MD_EDGE  = 3'h1;
   localparam logic [2:0] MD_LEVEL = 3'h2;
   localparam logic [2:0] MD_EXT   = 3'h3;
   localparam logic [2:0] MD_RTP   = 3'h5;
   // Playback engine states
   typedef enum logic [1:0] {P_IDLE = 2'b01, P_RUN = 2'b10} hdsp_play_t;
   // Serial slave states
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001, S_ADDR = 6'b000010, S_ACK = 6'b000100,
      S_WDAT = 6'b001000, S_RDAT = 6'b010000, S_RACK = 6'b100000
   } hdsp_i2c_st_t;
   // Register access strobe group
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hdsp_bus_t;
endpackage : hdsp_pkg

// file: logic/hdsp_i2c_slave.sv
// Two-wire serial register slave for the haptic setup and playback block
`timescale 1ns/10ps
module hdsp_i2c_slave
   import hdsp_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Serial pins
   input  wire logic       scl_pin,
   input  wire logic       sda_pin_i,
   output logic            sda_oe_n,
   // Register side
   input  wire logic       accept,
   input  wire logic [7:0] rdata,
   output logic [7:0]      rd_ptr,
   output hdsp_bus_t       bus
);
   logic         scl_m, scl_s, scl_p;  // Clock pin synchroniser and history
   logic         sda_m, sda_s, sda_p;  // Data pin synchroniser and history
   hdsp_i2c_st_t st_q, st_d;           // Frame state
   logic [3:0]   cnt_q, cnt_d;         // Bit count in byte
   logic [7:0]   sh_q, sh_d;           // Shift register
   logic [7:0]   ptr_q, ptr_d;         // Register pointer
   logic         rw_q, rw_d;           // Read frame
   logic         first_q, first_d;     // Next written byte is the pointer
   logic         oe_n_q, oe_n_d;       // Data pin pull-down, low drives
   hdsp_bus_t    bus_q, bus_d;         // Strobe group to registers
   logic         rise, fall, start, stop;

   // Only the second stage and history are looked at by logic
   assign rise  = scl_s & ~scl_p;
   assign fall  = ~scl_s & scl_p;
   assign start = scl_s & scl_p & sda_p & ~sda_s;
   assign stop  = scl_s & scl_p & ~sda_p & sda_s;
   assign sda_oe_n = oe_n_q;
   assign rd_ptr   = ptr_q;
   assign bus      = bus_q;

   // Next frame state
   always_comb begin
      logic load;
      load    = 1'b0;
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      first_d = first_q;
      oe_n_d  = oe_n_q;
      bus_d   = '0;
      if (stop) begin
         st_d   = S_IDLE;
         oe_n_d = 1'b1;
      end else if (start) begin
         st_d   = S_ADDR;
         cnt_d  = 4'h0;
         oe_n_d = 1'b1;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               oe_n_d = 1'b1;
            end
            S_ADDR: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall && cnt_q == 4'h8) begin
                  // Not answering keeps the device off the bus while not ready
                  if (sh_q[7:1] == DEV_ADDR && accept) begin  // RULE1
                     rw_d    = sh_q[0];
                     first_d = ~sh_q[0];
                     oe_n_d  = 1'b0;
                     st_d    = S_ACK;
                  end else begin
                     st_d = S_IDLE;
                  end
               end
            end
            S_ACK: begin
               if (fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     load = 1'b1;
                  end else begin
                     oe_n_d = 1'b1;
                     st_d   = S_WDAT;
                  end
               end
            end
            S_WDAT: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall && cnt_q == 4'h8) begin
                  oe_n_d  = 1'b0;
                  st_d    = S_ACK;
                  first_d = 1'b0;
                  if (first_q) begin
                     ptr_d = sh_q;
                  end else begin
                     bus_d.wr    = 1'b1;
                     bus_d.addr  = ptr_q;
                     bus_d.wdata = sh_q;
                     ptr_d       = ptr_q + 8'h01;
                  end
               end
            end
            S_RDAT: begin
               if (fall) begin
                  if (cnt_q == 4'h7) begin
                     oe_n_d = 1'b1;
                     st_d   = S_RACK;
                  end else begin
                     sh_d   = {sh_q[6:0], 1'b1};
                     oe_n_d = sh_q[6];
                     cnt_d  = cnt_q + 4'h1;
                  end
               end
            end
            S_RACK: begin
               // A released data line from the master ends the read
               if (rise && sda_s) begin
                  st_d = S_IDLE;
               end else if (fall) begin
                  cnt_d = 4'h0;
                  load  = 1'b1;
               end
            end
            default: begin
               st_d = S_IDLE;
            end
         endcase
      end
      // Load the next read byte and drive its top bit
      if (load) begin
         bus_d.rd   = 1'b1;
         bus_d.addr = ptr_q;
         sh_d       = rdata;
         oe_n_d     = rdata[7];
         ptr_d      = ptr_q + 8'h01;
         st_d       = S_RDAT;
      end
   end

   // Register stage, frozen while ce is low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
         st_q    <= S_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         ptr_q   <= 8'h00;
         rw_q    <= 1'b0;
         first_q <= 1'b0;
         oe_n_q  <= 1'b1;
         bus_q   <= '0;
      end else if (ce) begin
         {scl_m, scl_s, scl_p} <= {scl_pin, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_pin_i, sda_m, sda_s};
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         first_q <= first_d;
         oe_n_q  <= oe_n_d;
         bus_q   <= bus_d;
      end
   end
endmodule : hdsp_i2c_slave

// file: logic/hdsp_core.sv
// Register bank, power-up gate and playback engine of the haptic driver
`timescale 1ns/10ps
module hdsp_core
   import hdsp_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC  // Bus ignore time after reset
)(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Serial pins
   input  wire logic       scl_pin,
   input  wire logic       sda_pin_i,
   output logic            sda_pin_o,
   output logic            sda_oe_n,
   // Device pins
   input  wire logic       en_pin,
   input  wire logic       input_trigger_pin,
   // Drive side
   output logic [7:0]      drive_amp,
   output logic            drive_active,
   output logic            low_power,
   output logic            closed_loop,
   output logic            bidirectional,
   output logic            analog_sel
);
   hdsp_bus_t  bus;                    // Strobes from serial slave
   logic [7:0] rd_ptr;                 // Read pointer of serial slave
   logic [7:0] rdata;                  // Read data to serial slave
   logic       wr_ok;                  // Write taken this cycle
   // Pin synchronisers and power-up gate
   logic       en_m, en_s;
   logic       tr_m, tr_s, tr_p;
   logic [15:0] pcnt_q, pcnt_d;        // Power-up wait counter
   logic       rdy_q, rdy_d;           // Bus accepted once high
   // Configuration registers
   logic [7:0] mode_q, mode_d;
   logic [7:0] rtp_q, rtp_d;
   logic [7:0] loop1_q, loop1_d;
   logic [7:0] loop2_q, loop2_d;
   logic [7:0] loop3_q, loop3_d;
   logic [RAM_AW-1:0] raddr_q, raddr_d; // Waveform RAM window pointer
   logic [7:0] seq_q [SEQ_N];          // Effect index slots
   logic [7:0] seq_d [SEQ_N];
   logic [7:0] ram_q [RAM_N];          // Waveform memory
   // Playback engine
   hdsp_play_t pst_q, pst_d;
   logic [2:0] slot_q, slot_d;
   logic [9:0] tmr_q, tmr_d;
   logic [7:0] amp_q, amp_d;
   logic       act_q, act_d;
   logic       lp_q, lp_d;
   logic       lp, go_wr, start, stop_req, trig_rise;
   logic [2:0] mode_v;
   logic [6:0] eff;

   // Serial register slave, silent until the power-up wait ends
   hdsp_i2c_slave u_slave (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .scl_pin   (scl_pin),
      .sda_pin_i (sda_pin_i),
      .sda_oe_n  (sda_oe_n),
      .accept    (rdy_q),
      .rdata     (rdata),
      .rd_ptr    (rd_ptr),
      .bus       (bus)
   );

   assign sda_pin_o     = 1'b0;           // Open drain pulls low only
   assign wr_ok         = ce & bus.wr;
   assign drive_amp     = amp_q;
   assign drive_active  = act_q;
   assign low_power     = lp_q;
   assign closed_loop   = ~loop3_q[OPEN_LOOP_BIT];  // RULE6
   assign bidirectional = ~loop2_q[UNIDIR_BIT];     // RULE6
   assign analog_sel    = loop3_q[ANALOG_BIT];      // RULE15

   // Power-up wait; counting is cheaper than a timer block
   always_comb begin
      pcnt_d = pcnt_q;
      rdy_d  = rdy_q;
      if (!rdy_q) begin
         pcnt_d = pcnt_q + 16'h0001;
         rdy_d  = (pcnt_q == 16'(PWRUP_CYCLES - 1));  // RULE1
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {en_m, en_s}       <= 2'h0;
         {tr_m, tr_s, tr_p} <= 3'h0;
         pcnt_q <= 16'h0000;
         rdy_q  <= 1'b0;
      end else if (ce) begin
         {en_m, en_s}       <= {en_pin, en_m};
         {tr_m, tr_s, tr_p} <= {input_trigger_pin, tr_m, tr_s};
         pcnt_q <= pcnt_d;
         rdy_q  <= rdy_d;
      end
   end

   // Configuration writes; nothing here is cleared by low power
   always_comb begin
      mode_d  = mode_q;
      rtp_d   = rtp_q;
      loop1_d = loop1_q;
      loop2_d = loop2_q;
      loop3_d = loop3_q;
      raddr_d = raddr_q;
      if (wr_ok) begin
         unique case (bus.addr)
            REG_MODE:   mode_d  = bus.wdata;  // RULE3 RULE8
            REG_RTP:    rtp_d   = bus.wdata;  // RULE14
            REG_LOOP1:  loop1_d = bus.wdata;  // RULE6
            REG_LOOP2:  loop2_d = bus.wdata;  // RULE6
            REG_LOOP3:  loop3_d = bus.wdata;  // RULE6 RULE15
            REG_RAMHI:  raddr_d = {bus.wdata[0], raddr_q[7:0]};  // RULE5
            REG_RAMLO:  raddr_d = {raddr_q[8], bus.wdata};       // RULE5
            REG_RAMDAT: raddr_d = raddr_q + 9'h001;              // RULE5
            default:    mode_d  = mode_q;
         endcase
      end else if (ce && bus.rd && bus.addr == REG_RAMDAT) begin
         // Reads through the window step the pointer as writes do
         raddr_d = raddr_q + 9'h001;  // RULE5
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q  <= MODE_RST;
         rtp_q   <= ZERO_RST;
         loop1_q <= ZERO_RST;
         loop2_q <= ZERO_RST;
         loop3_q <= ZERO_RST;
         raddr_q <= '0;
      end else if (ce) begin  // RULE18
         mode_q  <= mode_d;
         rtp_q   <= rtp_d;
         loop1_q <= loop1_d;
         loop2_q <= loop2_d;
         loop3_q <= loop3_d;
         raddr_q <= raddr_d;
      end
   end

   // Waveform memory, written only through the data window
   always_ff @(posedge mclk) begin
      if (wr_ok && bus.addr == REG_RAMDAT) begin
         ram_q[raddr_q] <= bus.wdata;  // RULE5
      end
   end

   // Effect index slots, one per sequence step
   for (genvar i = 0; i < SEQ_N; i++) begin : g_seq
      always_comb begin
         seq_d[i] = seq_q[i];
         if (wr_ok && bus.addr == REG_SEQ0 + 8'(i)) begin
            seq_d[i] = bus.wdata;  // RULE10
         end
      end
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            seq_q[i] <= ZERO_RST;
         end else if (ce) begin
            seq_q[i] <= seq_d[i];
         end
      end
   end

   // Read data for the slave pointer
   always_comb begin
      logic [7:0] six;
      six   = rd_ptr - REG_SEQ0;
      rdata = 8'h00;
      if (rd_ptr >= REG_SEQ0 && rd_ptr <= REG_SEQ7) begin
         rdata = seq_q[six[2:0]];
      end else begin
         unique case (rd_ptr)
            REG_MODE:   rdata = mode_q;
            REG_RTP:    rdata = rtp_q;
            REG_GO:     rdata = {7'h00, pst_q == P_RUN};
            REG_LOOP1:  rdata = loop1_q;
            REG_LOOP2:  rdata = loop2_q;
            REG_LOOP3:  rdata = loop3_q;
            REG_RAMHI:  rdata = {7'h00, raddr_q[8]};
            REG_RAMLO:  rdata = raddr_q[7:0];
            REG_RAMDAT: rdata = ram_q[raddr_q];
            default:    rdata = 8'h00;  // Unmapped offsets read zero
         endcase
      end
   end

   // Start and stop conditions of the playback engine
   assign lp        = mode_q[STBY_BIT] | ~en_s;  // RULE7
   assign mode_v    = mode_q[2:0];
   assign go_wr     = wr_ok && bus.addr == REG_GO;
   assign trig_rise = tr_s & ~tr_p;
   assign eff       = seq_q[slot_q][6:0];
   // Go and trigger always restart from the first slot
   assign start = ~lp & ((mode_v == MD_INT && go_wr && bus.wdata[GO_BIT])  // RULE11 RULE13
                  | ((mode_v == MD_EDGE || mode_v == MD_LEVEL) && trig_rise));  // RULE12
   // Level trigger plays only while the pin stays high
   assign stop_req = lp | (mode_v == MD_LEVEL && !tr_s)  // RULE12
                  | (mode_v == MD_INT && go_wr && !bus.wdata[GO_BIT])
                  | (mode_v != MD_INT && mode_v != MD_EDGE && mode_v != MD_LEVEL);

   // Playback engine and drive amplitude
   always_comb begin
      pst_d  = pst_q;
      slot_d = slot_q;
      tmr_d  = tmr_q;
      unique case (pst_q)
         P_IDLE: begin
            if (start) begin
               pst_d  = P_RUN;
               slot_d = 3'h0;
               tmr_d  = 10'h000;
            end
         end
         P_RUN: begin
            if (start) begin
               slot_d = 3'h0;  // RULE13
               tmr_d  = 10'h000;
            end else if (stop_req || eff == 7'h00) begin
               pst_d = P_IDLE;  // Zero index ends a sequence early
            end else if (tmr_q == 10'(EFFECT_CYC - 1)) begin
               tmr_d = 10'h000;
               if (slot_q == 3'(SEQ_N - 1)) begin
                  pst_d = P_IDLE;
               end else begin
                  slot_d = slot_q + 3'h1;  // RULE10
               end
            end else begin
               tmr_d = tmr_q + 10'h001;
            end
         end
      endcase
      // Source of the drive amplitude by mode
      lp_d  = lp;
      amp_d = 8'h00;
      act_d = 1'b0;
      if (!lp) begin  // RULE7
         unique case (mode_v)  // RULE9
            MD_RTP: begin
               amp_d = rtp_q;  // RULE14
               act_d = 1'b1;
            end
            MD_EXT: begin
               // Pin level is passed on; duty or level shaping lies outside
               amp_d = tr_s ? 8'hFF : 8'h00;  // RULE15
               act_d = 1'b1;
            end
            MD_INT, MD_EDGE, MD_LEVEL: begin
               if (pst_q == P_RUN && eff != 7'h00) begin
                  amp_d = ram_q[RAM_AW'(eff)];
                  act_d = 1'b1;
               end
            end
            default: begin
               amp_d = 8'h00;  // Reserved codes leave the output idle
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pst_q  <= P_IDLE;
         slot_q <= 3'h0;
         tmr_q  <= 10'h000;
         amp_q  <= 8'h00;
         act_q  <= 1'b0;
         lp_q   <= 1'b1;
      end else if (ce) begin
         pst_q  <= pst_d;
         slot_q <= slot_d;
         tmr_q  <= tmr_d;
         amp_q  <= amp_d;
         act_q  <= act_d;
         lp_q   <= lp_d;
      end
   end

   // Checks on the register bank and the playback engine
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence go_write_s;
      ce && go_wr && bus.wdata[GO_BIT] && mode_v == MD_INT && !lp;
   endsequence
   sequence run_first_s;
      pst_q == P_RUN && slot_q == 3'h0 && tmr_q == 10'h000;
   endsequence

   bus_gate_a: assert property (!rdy_q |-> !bus.wr)  // RULE1
      else $error("register write before power-up wait ended");
   pwrup_time_a: assert property ($rose(rdy_q) |-> pcnt_q == 16'(PWRUP_CYCLES))  // RULE1
      else $error("power-up wait of wrong length");
   standby_exit_a: assert property (
      wr_ok && bus.addr == REG_MODE && bus.wdata == 8'h00 |=> !mode_q[STBY_BIT])  // RULE3
      else $error("zero write did not leave standby");
   mode_store_a: assert property (
      wr_ok && bus.addr == REG_MODE |=> mode_q == $past(bus.wdata))  // RULE8
      else $error("mode and standby not stored together");
   ram_step_a: assert property (
      wr_ok && bus.addr == REG_RAMDAT |=> raddr_q == $past(raddr_q) + 9'h001)  // RULE5
      else $error("RAM window pointer did not step");
   loop_cfg_a: assert property (
      wr_ok && bus.addr == REG_LOOP3 |=> closed_loop == !$past(bus.wdata[OPEN_LOOP_BIT]))  // RULE6
      else $error("loop mode not taken from write");
   low_power_a: assert property (ce && lp |=> lp_q && !act_q && amp_q == 8'h00)  // RULE7
      else $error("drive active in low power");
   go_start_a: assert property (go_write_s |=> run_first_s)  // RULE11 RULE13
      else $error("go write did not start first slot");
   trig_start_a: assert property (
      ce && !lp && trig_rise && (mode_v == MD_EDGE || mode_v == MD_LEVEL)
      |=> run_first_s)  // RULE12
      else $error("trigger edge did not start playback");
   slot_step_a: assert property (
      ce && pst_q == P_RUN && !start && !stop_req && eff != 7'h00
      && tmr_q == 10'(EFFECT_CYC - 1) && slot_q != 3'h7
      |=> slot_q == $past(slot_q) + 3'h1)  // RULE10
      else $error("sequence did not advance");
   rtp_drive_a: assert property (
      ce && !lp && mode_v == MD_RTP |=> amp_q == $past(rtp_q) && act_q)  // RULE14
      else $error("real-time amplitude not driven");
   mode_decode_a: assert property (
      ce && !lp && (mode_v == 3'h4 || mode_v > 3'h5) |=> !act_q)  // RULE9
      else $error("reserved mode drives output");
   hold_state_a: assert property (
      ce && lp && !bus.wr |=> $stable(mode_q) && $stable(rtp_q) && $stable(loop3_q))  // RULE18
      else $error("register changed in low power");
endmodule : hdsp_core

// file: bench/hdsp_host.sv
// Host processor model driving the two-wire serial register bus
`timescale 1ns/10ps
module hdsp_host
   import hdsp_pkg::*;
(
   // Clock
   input  wire logic mclk,
   // Serial pins
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_rel
);
   logic ack_q;  // Level seen in the last acknowledge slot
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // Waits n edges, then steps just past the edge
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : w
   // Phases of 5 clocks keep above the 4-clock synchroniser floor
   task automatic bit_x(input logic b, output logic s);
      w(5);
      sda_rel = b;
      w(5);
      scl = 1'b1;
      w(5);
      s = sda_wire;
      w(5);
      scl = 1'b0;
   endtask : bit_x
   // Released data line during the ninth bit samples the acknowledge
   task automatic byte_x(input logic [7:0] b, output logic [7:0] r);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
         r[i] = s;
      end
      bit_x(1'b1, ack_q);
   endtask : byte_x
   // Start, also used as repeated start
   task automatic start_x();
      sda_rel = 1'b1;
      w(5);
      scl = 1'b1;
      w(5);
      sda_rel = 1'b0;
      w(5);
      scl = 1'b0;
   endtask : start_x
   task automatic stop_x();
      w(5);
      sda_rel = 1'b0;
      w(5);
      scl = 1'b1;
      w(5);
      sda_rel = 1'b1;
      w(10);
   endtask : stop_x
   // Pointer byte, then one data byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start_x();
      byte_x({DEV_ADDR, 1'b0}, r);
      byte_x(a, r);
      byte_x(d, r);
      stop_x();
   endtask : wr
   // Master leaves the last byte unacknowledged
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      start_x();
      byte_x({DEV_ADDR, 1'b0}, r);
      byte_x(a, r);
      start_x();
      byte_x({DEV_ADDR, 1'b1}, r);
      byte_x(8'hFF, d);
      stop_x();
   endtask : rd
endmodule : hdsp_host

// file: bench/tb_top.sv
// Self-checking bench for the haptic setup and playback block
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
   import hdsp_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hdsp_row_t;
   logic mclk, rst, ce, en_pin, input_trigger_pin, scl_pin, sda_rel, sda_oe_n, sda_pin_o;
   logic drive_active, low_power, closed_loop, bidirectional, analog_sel;
   logic [7:0] drive_amp, r;
   wire  logic sda_pin_i = sda_rel & (sda_oe_n | sda_pin_o);  // Pulled-up open-drain line
   int bad_count = 0;
   int cmp_count = 0;
   // Offset 0x30 is unmapped and must read zero
   hdsp_row_t rows [6] = '{'{REG_LOOP2, 8'h80, 8'h80}, '{REG_LOOP3, 8'h22, 8'h22},
      '{REG_RTP, 8'h3C, 8'h3C}, '{REG_SEQ0, 8'h05, 8'h05},
      '{REG_SEQ7, 8'h09, 8'h09}, '{8'h30, 8'h77, 8'h00}};
   // Wait long enough that the first address byte ends inside it
   hdsp_core #(.PWRUP_CYCLES(300)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
      .scl_pin(scl_pin), .sda_pin_i(sda_pin_i), .sda_pin_o(sda_pin_o), .sda_oe_n(sda_oe_n),
      .en_pin(en_pin), .input_trigger_pin(input_trigger_pin), .drive_amp(drive_amp),
      .drive_active(drive_active), .low_power(low_power), .closed_loop(closed_loop),
      .bidirectional(bidirectional), .analog_sel(analog_sel));
   hdsp_host host_u (.mclk(mclk), .sda_wire(sda_pin_i), .scl(scl_pin), .sda_rel(sda_rel));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Run needs about 23k clocks
   initial begin
      #(60000 * 40);
      bad_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      en_pin = 1'b1;
      input_trigger_pin = 1'b0;
      host_u.w(5);
      rst = 1'b0;
      // Start lands inside the ignore window: no acknowledge
      host_u.start_x();
      host_u.byte_x({DEV_ADDR, 1'b0}, r);
      `CHK(host_u.ack_q, 1'b1)
      host_u.stop_x();
      `CHK({low_power, closed_loop, bidirectional, analog_sel}, 4'b1110)
      host_u.rd(REG_MODE, r);
      `CHK(r, MODE_RST)
      host_u.wr(REG_MODE, ZERO_RST);
      host_u.w(5);
      `CHK(low_power, 1'b0)
      foreach (rows[i]) begin
         host_u.wr(rows[i].a, rows[i].d);
         host_u.rd(rows[i].a, r);
         `CHK(r, rows[i].e)
      end
      `CHK({closed_loop, bidirectional, analog_sel}, 3'b001)
      // No calibration step; effect 5 amplitude through the window
      host_u.wr(REG_RAMHI, 8'h00);
      host_u.wr(REG_RAMLO, 8'h05);
      host_u.wr(REG_RAMDAT, 8'hA7);
      host_u.wr(REG_RAMLO, 8'h05);
      host_u.rd(REG_RAMDAT, r);
      `CHK(r, 8'hA7)
      host_u.wr(REG_GO, 8'h01);
      `CHK({drive_active, drive_amp}, 9'h1A7)
      host_u.rd(REG_GO, r);
      `CHK(r[GO_BIT], 1'b1)
      // Zero in slot 1 ends the sequence
      for (int i = 0; i < 1500 && drive_active !== 1'b0; i++) host_u.w(1);
      `CHK(drive_active, 1'b0)
      host_u.wr(REG_GO, 8'h01);
      `CHK(drive_active, 1'b1)
      // Standby and real-time mode stored in one write
      host_u.wr(REG_MODE, 8'h45);
      host_u.w(5);
      `CHK(low_power, 1'b1)
      host_u.rd(REG_MODE, r);
      `CHK(r, 8'h45)
      host_u.rd(REG_SEQ0, r);
      `CHK(r, 8'h05)
      host_u.wr(REG_MODE, 8'h05);
      host_u.w(3);
      `CHK(drive_amp, 8'h3C)
      host_u.wr(REG_RTP, 8'h81);
      host_u.w(3);
      `CHK(drive_amp, 8'h81)
      en_pin = 1'b0;
      host_u.w(8);
      `CHK(low_power, 1'b1)
      en_pin = 1'b1;
      host_u.w(8);
      // Edge, level, analog input, then a reserved code on the trigger pin
      for (int m = 1; m < 5; m++) begin
         host_u.wr(8'(m), 8'h00);
         host_u.wr(REG_MODE, 8'(m));
         input_trigger_pin = 1'b1;
         host_u.w(8);
         `CHK(drive_amp, (m == 3) ? 8'hFF : (m == 4) ? 8'h00 : 8'hA7)
         input_trigger_pin = 1'b0;
         host_u.w(8);
         if (m == 2 || m == 4) `CHK(drive_active, 1'b0)
      end
      // Frozen clock enable keeps low power off although enable falls
      ce = 1'b0;
      en_pin = 1'b0;
      host_u.w(8);
      `CHK(low_power, 1'b0)
      ce = 1'b1;
      host_u.w(8);
      `CHK(low_power, 1'b1)
      // Reset in mid-run restores the default drive setup
      rst = 1'b1;
      host_u.w(2);
      `CHK({low_power, closed_loop, bidirectional, analog_sel, drive_active}, 5'b11100)
      rst = 1'b0;
      host_u.w(2);
      `CHK({low_power, closed_loop, bidirectional, analog_sel, drive_amp}, 12'hE00)
      report_and_stop();
   end
endmodule : tb_top
